/* File: logic/acmx_pkg.sv */
// Constants, codes and types shared by the crosspoint control block.
// Assumes a single 250 MHz system clock; all counts except U1_IDLE_CYC derive from it.
package acmx_pkg;
	// ==========================================================
	// Timing
	localparam int SYS_CLK_KHZ    = 250000;
	localparam int STRAP_HOLD_US  = 10;
	localparam int STRAP_HOLD_CYC = (STRAP_HOLD_US * SYS_CLK_KHZ + 999) / 1000;
	localparam int SBU_OPEN_MS    = 2;
	localparam int SBU_OPEN_CYC   = SBU_OPEN_MS * SYS_CLK_KHZ;
	localparam int U1_IDLE_CYC    = 256;
	// ==========================================================
	// Strap pins
	localparam int STRAP_NUM    = 7;
	localparam int STRAP_IFSEL  = 0;
	localparam int STRAP_UP0    = 1;
	localparam int STRAP_UP1    = 2;
	localparam int STRAP_DN0    = 3;
	localparam int STRAP_DN1    = 4;
	localparam int STRAP_DP0    = 5;
	localparam int STRAP_DP1    = 6;
	localparam logic [1:0] LVL_ZERO  = 2'h0;
	localparam logic [1:0] LVL_RES   = 2'h1;
	localparam logic [1:0] LVL_FLOAT = 2'h2;
	localparam logic [1:0] LVL_ONE   = 2'h3;
	// ==========================================================
	// Register offsets and fields
	localparam logic [7:0] OFS_CFG       = 8'h0a;
	localparam logic [7:0] OFS_DP_EQ     = 8'h10;
	localparam logic [7:0] OFS_SINK      = 8'h12;
	localparam logic [7:0] OFS_SNOOP     = 8'h13;
	localparam logic [7:0] OFS_STATUS    = 8'h14;
	localparam logic [7:0] OFS_USB_UP_EQ = 8'h20;
	localparam logic [7:0] OFS_USB_DN_EQ = 8'h21;
	localparam int CFG_USB_BIT   = 0;
	localparam int CFG_DP_BIT    = 1;
	localparam int CFG_FLIP_BIT  = 2;
	localparam int SNOOP_DIS_BIT = 0;
	localparam int LANE_DIS_LSB  = 1;
	localparam int SINK_LANE_LSB = 0;
	localparam int SINK_PWR_LSB  = 5;
	localparam logic [7:0] RST_REG = 8'h00;
	// ==========================================================
	// Sink register snooping
	localparam logic [19:0] DPCD_LANE_COUNT = 20'h00101;
	localparam logic [19:0] DPCD_POWER      = 20'h00600;
	localparam logic [2:0]  PWR_D3          = 3'h2;
	localparam logic [4:0]  LANES_ONE       = 5'h01;
	localparam logic [4:0]  LANES_TWO       = 5'h02;
	localparam logic [3:0]  MASK_FOUR       = 4'hf;
	localparam logic [3:0]  MASK_TWO        = 4'h3;
	localparam logic [3:0]  MASK_ONE        = 4'h1;
	// ==========================================================
	// Types
	typedef enum logic [1:0] {SBU_OPEN, SBU_NORMAL, SBU_SWAP} acmx_sbu_t;
	typedef enum logic [1:0] {USB_DISC, USB_U0, USB_U1, USB_U23} acmx_usb_t;
endpackage

/* File: logic/acmx_strap_if.sv */
// Carrier for latched strap levels between strap capture and control.
// Assumes both ends run on the system clock.
`timescale 1ns/100ps
`default_nettype none
interface acmx_strap_if;
	logic [6:0][1:0] level;
	logic            latch_pulse;
	logic            pull_iso;
	modport src (output level, output latch_pulse, output pull_iso);
	modport dst (input level, input latch_pulse, input pull_iso);
endinterface
`default_nettype wire

/* File: logic/acmx_strap.sv */
// Four-level strap capture: decodes comparator thermometers per pin.
// Assumes comparator outputs settle before internal reset releases.
`timescale 1ns/100ps
`default_nettype none
module acmx_strap
	import acmx_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_b,
	input  wire logic [20:0] i_strap_cmp,
	acmx_strap_if.src        sif
);
	logic [6:0][1:0] level_r, level_nxt;
	logic            latched_r, latched_nxt;
	logic            pulse_r, pulse_nxt;
	logic [11:0]     hold_r, hold_nxt;
	logic            iso_r, iso_nxt;
	logic [6:0][1:0] decoded;

	// ==========================================================
	// Thermometer decode per pin
	genvar g;
	generate
		for (g = 0; g < STRAP_NUM; g++) begin : g_dec
			// 000 zero, 001 resistor, 011 float, 111 one; see RULE21
			assign decoded[g] = {i_strap_cmp[3*g+1],
				(i_strap_cmp[3*g] & ~i_strap_cmp[3*g+1]) | i_strap_cmp[3*g+2]};
		end
	endgenerate

	// Capture once after release, then isolate pulls after hold
	always_comb begin
		level_nxt   = level_r;
		latched_nxt = 1'b1;
		pulse_nxt   = 1'b0;
		hold_nxt    = hold_r;
		iso_nxt     = iso_r;
		if (!latched_r) begin
			level_nxt = decoded; // see RULE20
			pulse_nxt = 1'b1;
		end else if (!iso_r) begin
			hold_nxt = hold_r + 12'h001;
			if (hold_r == 12'(STRAP_HOLD_CYC - 1)) begin
				iso_nxt = 1'b1; // see RULE20
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			level_r   <= '0;
			latched_r <= 1'b0;
			pulse_r   <= 1'b0;
			hold_r    <= 12'h000;
			iso_r     <= 1'b0;
		end else begin
			level_r   <= level_nxt;
			latched_r <= latched_nxt;
			pulse_r   <= pulse_nxt;
			hold_r    <= hold_nxt;
			iso_r     <= iso_nxt;
		end
	end

	assign sif.level       = level_r;
	assign sif.latch_pulse = pulse_r;
	assign sif.pull_iso    = iso_r;

	// ==========================================================
	// Checks
	chk_strap_iso_time: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		$rose(pulse_r) |-> !iso_r [*8]) // see RULE20
		else $error("pull isolation came too early");
	chk_strap_stable: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		latched_r && !pulse_r |-> $stable(level_r)) // see RULE20
		else $error("strap level changed after latch");
endmodule // acmx_strap
`default_nettype wire

/* File: logic/acmx_snoop.sv */
// Auxiliary write snooper: keeps last sink lane count and power state.
// Assumes an upstream decoder presents native writes as one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
module acmx_snoop
	import acmx_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_enable,
	input  wire logic        i_wr_valid,
	input  wire logic [19:0] i_wr_addr,
	input  wire logic [7:0]  i_wr_data,
	output logic      [4:0]  o_lane_count,
	output logic      [2:0]  o_power_state
);
	logic [4:0] lane_r, lane_nxt;
	logic [2:0] pwr_r, pwr_nxt;

	// Only writes seen while enabled update; stale values persist
	always_comb begin
		lane_nxt = lane_r;
		pwr_nxt  = pwr_r;
		if (i_enable && i_wr_valid) begin
			if (i_wr_addr == DPCD_LANE_COUNT) begin
				lane_nxt = i_wr_data[4:0]; // see RULE12
			end
			if (i_wr_addr == DPCD_POWER) begin
				pwr_nxt = i_wr_data[2:0]; // see RULE12
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lane_r <= 5'h00;
			pwr_r  <= 3'h0;
		end else begin
			lane_r <= lane_nxt;
			pwr_r  <= pwr_nxt;
		end
	end

	assign o_lane_count  = lane_r;
	assign o_power_state = pwr_r;

	chk_snoop_lane_cap: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_enable && i_wr_valid && i_wr_addr == DPCD_LANE_COUNT
		|=> lane_r == $past(i_wr_data[4:0])) // see RULE12
		else $error("lane count write not captured");
	chk_snoop_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		!i_enable |=> $stable(lane_r) && $stable(pwr_r)) // see RULE16
		else $error("snoop fields moved while disabled");
endmodule // acmx_snoop
`default_nettype wire

/* File: logic/acmx_top.sv */
// Crosspoint control: configuration decode, lane routing, sideband map,
// lane power management, equalization select and USB state tracking.
// Assumes pins synchronous to i_sys_clk and a register port fed by an I2C core.
//
// Contract
// RULE1: Interface select level zero means pin mode.
// RULE2: Enable pins decode to four configurations.
// RULE3: Display enable gates display; orientation flips.
// RULE4: Power-up defaults to USB configuration.
// RULE5: Controller pulses USB enable when unattached.
// RULE6: Sidebands follow orientation; open after 2ms.
// RULE7: USB uses pair a, pair b flipped.
// RULE8: Four-lane order follows orientation.
// RULE9: Two-lane plus USB order follows orientation.
// RULE10: LFPS disables receiver equalization.
// RULE11: USB state from physical conditions only.
// RULE12: Snoop sink lane-count and power writes.
// RULE13: Lanes follow snooped count unless D3.
// RULE14: D3 disables all display lanes.
// RULE15: Snoop on at reset; disable uses registers.
// RULE16: Pin mode: no snoop, all lanes.
// RULE17: Snooped values appear at snooped_sink_state.
// RULE18: Software disables snoop on bad traffic.
// RULE19: Source sends standard sync patterns.
// RULE20: Straps latched at reset; pulls isolated later.
// RULE21: Each strap decodes to four levels.
// RULE22: Two straps give sixteen settings per path.
// RULE23: Register bits replace pins in I2C mode.
// RULE24: Display data needs enable and hot plug.
`timescale 1ns/100ps
`default_nettype none
module acmx_top
	import acmx_pkg::*;
#(
	parameter int SBU_OPEN_COUNT = SBU_OPEN_CYC,
	parameter int U1_IDLE_COUNT  = U1_IDLE_CYC
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_usb_enable_pin,
	input  wire logic        i_display_enable_pin,
	input  wire logic        i_orientation_pin,
	input  wire logic        i_hot_plug_input,
	input  wire logic [20:0] i_strap_cmp,
	input  wire logic        i_lfps_up,
	input  wire logic        i_lfps_down,
	input  wire logic        i_far_term,
	input  wire logic        i_elec_idle,
	input  wire logic        i_ss_signal,
	input  wire logic        i_aux_wr_valid,
	input  wire logic [19:0] i_aux_wr_addr,
	input  wire logic [7:0]  i_aux_wr_data,
	input  wire logic        i_reg_wr,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	output logic      [7:0]  o_reg_rdata,
	output logic             o_i2c_mode,
	output logic             o_power_down,
	output logic             o_usb_route_en,
	output logic             o_usb_pair_b,
	output logic      [3:0]  o_lane_en,
	output logic      [7:0]  o_lane_src,
	output logic      [1:0]  o_sbu_map,
	output logic      [3:0]  o_usb_up_eq,
	output logic             o_usb_up_eq_en,
	output logic      [3:0]  o_usb_down_eq,
	output logic             o_usb_down_eq_en,
	output logic      [3:0]  o_display_eq,
	output logic             o_strap_pull_iso,
	output logic      [1:0]  o_usb_state
);
	acmx_strap_if sif ();
	logic [4:0] snp_lanes;
	logic [2:0] snp_pwr;
	logic       usb_en, dp_en, flip, snoop_on;

	// ==========================================================
	// Submodules
	acmx_strap acmx_strap_inst (
		.i_sys_clk   (i_sys_clk),
		.i_rst_b     (i_rst_b),
		.i_strap_cmp (i_strap_cmp),
		.sif         (sif)
	);

	acmx_snoop acmx_snoop_inst (
		.i_sys_clk     (i_sys_clk),
		.i_rst_b       (i_rst_b),
		.i_enable      (snoop_on),
		.i_wr_valid    (i_aux_wr_valid),
		.i_wr_addr     (i_aux_wr_addr),
		.i_wr_data     (i_aux_wr_data),
		.o_lane_count  (snp_lanes),
		.o_power_state (snp_pwr)
	);

	// ==========================================================
	// Registers
	logic [7:0] cfg_r, cfg_nxt, snoop_r, snoop_nxt, rdata_r, rdata_nxt;
	logic [7:0] up_eq_r, up_eq_nxt;
	logic [3:0] dn_eq_r, dn_eq_nxt, dp_eq_r, dp_eq_nxt;
	logic       i2c_r;
	logic [3:0] lane_en_r;
	acmx_usb_t  usb_r, usb_nxt;
	acmx_sbu_t  sbu_r, sbu_nxt;

	// Strap latch preloads the EQ registers, so both sources agree
	always_comb begin
		cfg_nxt   = cfg_r;
		snoop_nxt = snoop_r;
		up_eq_nxt = up_eq_r;
		dn_eq_nxt = dn_eq_r;
		dp_eq_nxt = dp_eq_r;
		if (sif.latch_pulse) begin
			// Pin 0 of each pair is the upper half of the setting; see RULE22
			up_eq_nxt = {sif.level[STRAP_UP0], sif.level[STRAP_UP1],
				sif.level[STRAP_UP0], sif.level[STRAP_UP1]};
			dn_eq_nxt = {sif.level[STRAP_DN0], sif.level[STRAP_DN1]};
			dp_eq_nxt = {sif.level[STRAP_DP0], sif.level[STRAP_DP1]};
		end else if (i_reg_wr) begin
			unique case (i_reg_addr)
				OFS_CFG:       cfg_nxt   = i_reg_wdata; // see RULE23
				OFS_SNOOP:     snoop_nxt = i_reg_wdata; // see RULE15
				OFS_USB_UP_EQ: up_eq_nxt = i_reg_wdata; // see RULE22
				OFS_USB_DN_EQ: dn_eq_nxt = i_reg_wdata[3:0];
				OFS_DP_EQ:     dp_eq_nxt = i_reg_wdata[3:0];
				default:       cfg_nxt   = cfg_r;
			endcase
		end
		// Unmapped reads answer zero
		unique case (i_reg_addr)
			OFS_CFG:       rdata_nxt = cfg_r;
			OFS_SNOOP:     rdata_nxt = snoop_r;
			OFS_SINK:      rdata_nxt = {snp_pwr, snp_lanes}; // see RULE17
			OFS_STATUS:    rdata_nxt = {2'h0, lane_en_r, 2'(usb_r)};
			OFS_USB_UP_EQ: rdata_nxt = up_eq_r;
			OFS_USB_DN_EQ: rdata_nxt = {4'h0, dn_eq_r};
			OFS_DP_EQ:     rdata_nxt = {4'h0, dp_eq_r};
			default:       rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cfg_r   <= RST_REG;
			snoop_r <= RST_REG; // Snoop enabled out of reset; see RULE15
			up_eq_r <= RST_REG;
			dn_eq_r <= 4'h0;
			dp_eq_r <= 4'h0;
			rdata_r <= 8'h00;
		end else begin
			cfg_r   <= cfg_nxt;
			snoop_r <= snoop_nxt;
			up_eq_r <= up_eq_nxt;
			dn_eq_r <= dn_eq_nxt;
			dp_eq_r <= dp_eq_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ==========================================================
	// Configuration source and power-up default
	logic       seen_r, seen_nxt, ref_ok_r, ref_ok_nxt, i2c_nxt;
	logic [2:0] ref_r, ref_nxt, pins;

	assign pins = {i_display_enable_pin, i_usb_enable_pin, i_orientation_pin};

	// USB stays on until the pins first move from their reset values
	always_comb begin
		ref_ok_nxt = 1'b1;
		ref_nxt    = ref_ok_r ? ref_r : pins;
		seen_nxt   = seen_r | (ref_ok_r && pins != ref_r); // see RULE4
		i2c_nxt    = sif.level[STRAP_IFSEL] != LVL_ZERO; // see RULE1
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ref_ok_r <= 1'b0;
			ref_r    <= 3'h0;
			seen_r   <= 1'b0;
			i2c_r    <= 1'b0;
		end else begin
			ref_ok_r <= ref_ok_nxt;
			ref_r    <= ref_nxt;
			seen_r   <= seen_nxt;
			i2c_r    <= i2c_nxt;
		end
	end

	// Register bits replace pins in I2C mode; see RULE23
	always_comb begin
		if (i2c_r) begin
			usb_en = cfg_r[CFG_USB_BIT];
			dp_en  = cfg_r[CFG_DP_BIT];
			flip   = cfg_r[CFG_FLIP_BIT];
		end else if (!seen_r) begin
			usb_en = 1'b1; // see RULE4
			dp_en  = 1'b0;
			flip   = 1'b0;
		end else begin
			usb_en = i_usb_enable_pin; // see RULE2
			dp_en  = i_display_enable_pin; // see RULE3
			flip   = i_orientation_pin; // see RULE3
		end
		snoop_on = i2c_r && !snoop_r[SNOOP_DIS_BIT] && dp_en; // see RULE16
	end

	// ==========================================================
	// Lane management, sideband map and USB state
	logic [3:0]  cfg_mask, cnt_mask, lane_en_nxt;
	logic [18:0] sbu_cnt_r, sbu_cnt_nxt;
	logic [8:0]  idle_r, idle_nxt;

	always_comb begin
		// Both-high keeps lanes 0 and 1 only; see RULE2
		cfg_mask = !dp_en ? 4'h0 : (usb_en ? MASK_TWO : MASK_FOUR);
		unique case (snp_lanes)
			LANES_ONE: cnt_mask = MASK_ONE;
			LANES_TWO: cnt_mask = MASK_TWO;
			default:   cnt_mask = MASK_FOUR;
		endcase
		if (!(dp_en && i_hot_plug_input)) begin
			lane_en_nxt = 4'h0; // see RULE24
		end else if (!i2c_r) begin
			lane_en_nxt = cfg_mask; // see RULE16
		end else if (snoop_r[SNOOP_DIS_BIT]) begin
			lane_en_nxt = cfg_mask & ~snoop_r[LANE_DIS_LSB +: 4]; // see RULE15
		end else if (snp_pwr == PWR_D3) begin
			lane_en_nxt = 4'h0; // see RULE14
		end else begin
			lane_en_nxt = cfg_mask & cnt_mask; // see RULE13
		end
		// Sidebands hold their map through short display-enable drops
		sbu_nxt     = sbu_r;
		sbu_cnt_nxt = sbu_cnt_r;
		if (dp_en) begin
			sbu_cnt_nxt = 19'h00000;
			sbu_nxt     = flip ? SBU_SWAP : SBU_NORMAL; // see RULE6
		end else if (sbu_cnt_r != 19'(SBU_OPEN_COUNT)) begin
			sbu_cnt_nxt = sbu_cnt_r + 19'h00001;
		end else begin
			sbu_nxt = SBU_OPEN; // see RULE6
		end
		// Physical conditions only, no traffic decode; see RULE11
		usb_nxt  = usb_r;
		idle_nxt = 9'h000;
		if (!usb_en || !i_far_term) begin
			usb_nxt = USB_DISC;
		end else begin
			unique case (usb_r)
				USB_DISC: usb_nxt = USB_U0;
				USB_U0:   usb_nxt = i_elec_idle ? USB_U1 : USB_U0;
				USB_U1: begin
					idle_nxt = idle_r + 9'h001;
					if (i_ss_signal || i_lfps_up || i_lfps_down) begin
						usb_nxt = USB_U0;
					end else if (idle_r == 9'(U1_IDLE_COUNT - 1)) begin
						usb_nxt = USB_U23;
					end
				end
				USB_U23:  usb_nxt = (i_lfps_up || i_lfps_down) ? USB_U0 : USB_U23;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lane_en_r <= 4'h0;
			sbu_r     <= SBU_OPEN;
			sbu_cnt_r <= 19'h00000;
			usb_r     <= USB_DISC;
			idle_r    <= 9'h000;
		end else begin
			lane_en_r <= lane_en_nxt;
			sbu_r     <= sbu_nxt;
			sbu_cnt_r <= sbu_cnt_nxt;
			usb_r     <= usb_nxt;
			idle_r    <= idle_nxt;
		end
	end

	// ==========================================================
	// Output registers
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_power_down     <= 1'b0;
			o_usb_route_en   <= 1'b0;
			o_usb_pair_b     <= 1'b0;
			o_lane_src       <= 8'h00;
			o_usb_up_eq      <= 4'h0;
			o_usb_up_eq_en   <= 1'b0;
			o_usb_down_eq    <= 4'h0;
			o_usb_down_eq_en <= 1'b0;
			o_display_eq     <= 4'h0;
		end else begin
			o_power_down     <= !usb_en && !dp_en; // see RULE2
			o_usb_route_en   <= usb_en; // see RULE7
			o_usb_pair_b     <= flip; // see RULE7
			// Lane i takes TXB,RXB,RXA,TXA unflipped, reversed flipped; see RULE8
			o_lane_src       <= flip ? 8'he4 : 8'h1b; // see RULE9
			o_usb_up_eq      <= flip ? up_eq_r[7:4] : up_eq_r[3:0];
			o_usb_up_eq_en   <= !i_lfps_up; // see RULE10
			o_usb_down_eq    <= dn_eq_r;
			o_usb_down_eq_en <= !i_lfps_down; // see RULE10
			o_display_eq     <= dp_eq_r;
		end
	end

	assign o_reg_rdata      = rdata_r;
	assign o_i2c_mode       = i2c_r;
	assign o_lane_en        = lane_en_r;
	assign o_sbu_map        = 2'(sbu_r);
	assign o_strap_pull_iso = sif.pull_iso;
	assign o_usb_state      = 2'(usb_r);

	// ==========================================================
	// Checks
	chk_lfps_eq_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_lfps_up |=> !o_usb_up_eq_en) // see RULE10
		else $error("equalization on during LFPS");
	chk_d3_lanes_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i2c_r && !snoop_r[SNOOP_DIS_BIT] && snp_pwr == PWR_D3 |=> o_lane_en == 4'h0)
		else $error("lanes active in D3"); // see RULE14
	chk_hpd_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		!i_hot_plug_input |=> o_lane_en == 4'h0) // see RULE24
		else $error("lanes active without hot plug");
	chk_pin_all_lanes: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		!i2c_r && seen_r && i_display_enable_pin && !i_usb_enable_pin && i_hot_plug_input
		|=> o_lane_en == 4'hf) // see RULE16
		else $error("pin mode four lanes not enabled");
	chk_sbu_open_late: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		$fell(dp_en) && sbu_r != SBU_OPEN |-> sbu_r != SBU_OPEN [*8]) // see RULE6
		else $error("sidebands opened too early");
	chk_powerup_usb: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		!i2c_r && !seen_r |=> o_usb_route_en && !o_power_down) // see RULE4
		else $error("power-up default not USB");
	chk_sink_readback: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_reg_addr == OFS_SINK |=> o_reg_rdata == {$past(snp_pwr), $past(snp_lanes)})
		else $error("sink state readback wrong"); // see RULE17
	cov_four_lane: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		o_lane_en == 4'hf);
	cov_sbu_swap: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		sbu_r == SBU_SWAP ##1 sbu_r == SBU_OPEN);
	cov_usb_u23: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		usb_r == USB_U23 ##1 usb_r == USB_U0);
endmodule // acmx_top
`default_nettype wire

/* File: sim/acmx_pd_model.sv */
// Power-delivery controller stand-in: drives control and hot-plug pins.
// Assumes callers use its tasks from the system clock domain.
`timescale 1ns/100ps
`default_nettype none
module acmx_pd_model (
	input  wire logic i_sys_clk,
	output var  logic o_usb,
	output var  logic o_dp,
	output var  logic o_flip,
	output var  logic o_hpd
);
	// ==========================================================
	// Pin driving
	// All pins low until the bench asks for a configuration
	initial begin
		{o_usb, o_dp, o_flip, o_hpd} = 4'h0;
	end

	// Pins move just after an edge and then stand
	task automatic set_cfg(input logic u, d, f, h);
		@(posedge i_sys_clk);
		{o_usb, o_dp, o_flip, o_hpd} <= {u, d, f, h};
	endtask

	// Nothing attached: low-high-low pulse on USB enable
	task automatic detach();
		set_cfg(1'b1, o_dp, o_flip, o_hpd);
		repeat (3) @(posedge i_sys_clk);
		set_cfg(1'b0, o_dp, o_flip, o_hpd);
	endtask
endmodule // acmx_pd_model
`default_nettype wire

/* File: sim/acmx_top_test.sv */
// Self-checking bench for the crosspoint control block.
// Assumes the partner model drives control pins; bench drives the rest.
`timescale 1ns/100ps
`default_nettype none
module acmx_top_test;
	import acmx_pkg::*;
	// ==========================================================
	// Signals
	localparam logic [20:0] STRAP_PIN = 21'h008ec8; // Up R/F, down 1/0, dp R/0
	localparam logic [20:0] STRAP_I2C = 21'h000e0f;
	logic        clk, rst_b, usb, dp, flip, hpd, lfps_up, lfps_dn, term, idle, ss;
	logic        aux_v, reg_wr, i2c, pdn, usb_en, pair_b, up_en, dn_en, iso;
	logic [20:0] strap;
	logic [19:0] aux_a;
	logic [7:0]  aux_d, reg_a, reg_d, rdata, lane_src;
	logic [3:0]  lane_en, up_eq, dn_eq, dp_eq;
	logic [1:0]  sbu, ustate;
	int          error_cnt, n_tests;

	acmx_pd_model acmx_pd_model_inst (.i_sys_clk(clk), .o_usb(usb), .o_dp(dp),
		.o_flip(flip), .o_hpd(hpd));
	// Short sideband and idle counts keep the run brief
	acmx_top #(.SBU_OPEN_COUNT(20), .U1_IDLE_COUNT(8)) acmx_top_inst (
		.i_sys_clk(clk), .i_rst_b(rst_b), .i_usb_enable_pin(usb),
		.i_display_enable_pin(dp), .i_orientation_pin(flip), .i_hot_plug_input(hpd),
		.i_strap_cmp(strap), .i_lfps_up(lfps_up), .i_lfps_down(lfps_dn),
		.i_far_term(term), .i_elec_idle(idle), .i_ss_signal(ss),
		.i_aux_wr_valid(aux_v), .i_aux_wr_addr(aux_a), .i_aux_wr_data(aux_d),
		.i_reg_wr(reg_wr), .i_reg_addr(reg_a), .i_reg_wdata(reg_d),
		.o_reg_rdata(rdata), .o_i2c_mode(i2c), .o_power_down(pdn),
		.o_usb_route_en(usb_en), .o_usb_pair_b(pair_b), .o_lane_en(lane_en),
		.o_lane_src(lane_src), .o_sbu_map(sbu), .o_usb_up_eq(up_eq),
		.o_usb_up_eq_en(up_en), .o_usb_down_eq(dn_eq), .o_usb_down_eq_en(dn_en),
		.o_display_eq(dp_eq), .o_strap_pull_iso(iso), .o_usb_state(ustate));

	// ==========================================================
	// Helpers
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Sample just past the edge so registered outputs have landed
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic do_reset(input logic [20:0] s);
		@(posedge clk);
		rst_b <= 1'b0;
		strap <= s;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		{reg_wr, reg_a, reg_d} <= {1'b1, a, d};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// No read strobe: data follows the held address one cycle later
	task automatic rd(input logic [7:0] a, exp);
		@(posedge clk);
		reg_a <= a;
		wait_n(2);
		chk("reg_rdata", rdata, exp);
	endtask
	task automatic aux(input logic [19:0] a, input logic [7:0] d);
		@(posedge clk);
		{aux_v, aux_a, aux_d} <= {1'b1, a, d};
		@(posedge clk);
		aux_v <= 1'b0;
		wait_n(3);
	endtask
	task automatic test_done();
		$display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_default();
		wait_n(4);
		chk("i2c_mode", {7'h0, i2c}, 8'h00);
		chk("usb_default", {6'h0, usb_en, pdn}, 8'h02);
		chk("pull_iso_early", {7'h0, iso}, 8'h00);
		acmx_pd_model_inst.detach();
		wait_n(4);
		chk("detach_pdn", {7'h0, pdn}, 8'h01);
	endtask
	task automatic t_configs();
		logic u, d, f;
		for (int i = 0; i < 8; i++) begin
			{d, u, f} = i[2:0];
			acmx_pd_model_inst.set_cfg(u, d, f, 1'b1);
			wait_n(4);
			chk("power_down", {7'h0, pdn}, {7'h0, !d && !u});
			chk("lane_en", {4'h0, lane_en}, d ? (u ? 8'h03 : 8'h0f) : 8'h00);
			if (u) chk("usb_pair", {6'h0, usb_en, pair_b}, {7'h01, f});
			if (d) chk("lane_src", lane_src, f ? 8'he4 : 8'h1b);
			if (d) chk("sbu_map", {6'h0, sbu}, f ? 8'h02 : 8'h01);
		end
		acmx_pd_model_inst.set_cfg(1'b0, 1'b1, 1'b0, 1'b0);
		wait_n(4);
		chk("lane_no_hpd", {4'h0, lane_en}, 8'h00);
		acmx_pd_model_inst.set_cfg(1'b0, 1'b0, 1'b0, 1'b0);
		wait_n(16);
		chk("sbu_held", {6'h0, sbu}, 8'h01);
		wait_n(8);
		chk("sbu_open", {6'h0, sbu}, 8'h00);
	endtask
	// Straps set up R/F and down 1/0; both paths lose gain in LFPS
	task automatic t_eq();
		acmx_pd_model_inst.set_cfg(1'b1, 1'b0, 1'b0, 1'b0);
		wait_n(4);
		chk("up_eq", {3'h0, up_en, up_eq}, 8'h16);
		chk("dn_eq", {3'h0, dn_en, dn_eq}, 8'h1c);
		chk("dp_eq", {4'h0, dp_eq}, 8'h04);
		@(posedge clk);
		{lfps_up, lfps_dn} <= 2'h3;
		wait_n(3);
		chk("eq_en_lfps", {6'h0, up_en, dn_en}, 8'h00);
		@(posedge clk);
		{lfps_up, lfps_dn} <= 2'h0;
	endtask
	task automatic t_usb();
		@(posedge clk);
		term <= 1'b1;
		wait_n(4);
		chk("usb_u0", {6'h0, ustate}, 8'h01);
		@(posedge clk);
		idle <= 1'b1;
		wait_n(3);
		chk("usb_u1", {6'h0, ustate}, 8'h02);
		@(posedge clk);
		ss <= 1'b1;
		wait_n(1);
		chk("usb_ss_wake", {6'h0, ustate}, 8'h01);
		@(posedge clk);
		ss <= 1'b0;
		wait_n(12);
		chk("usb_u23", {6'h0, ustate}, 8'h03);
		@(posedge clk);
		{idle, lfps_up} <= 2'h1;
		wait_n(3);
		chk("usb_wake", {6'h0, ustate}, 8'h01);
		@(posedge clk);
		{term, lfps_up} <= 2'h0;
		wait_n(3);
		chk("usb_disc", {6'h0, ustate}, 8'h00);
	endtask
	task automatic t_snoop();
		do_reset(STRAP_I2C);
		acmx_pd_model_inst.set_cfg(1'b0, 1'b0, 1'b0, 1'b1);
		wait_n(4);
		chk("i2c_mode_on", {7'h0, i2c}, 8'h01);
		rd(OFS_SNOOP, RST_REG);
		rd(OFS_SINK, RST_REG);
		wr(OFS_CFG, 8'h02);
		wait_n(3);
		chk("reg_dp_lanes", {4'h0, lane_en}, 8'h0f);
		aux(DPCD_LANE_COUNT, 8'h01);
		chk("snoop_one", {4'h0, lane_en}, 8'h01);
		rd(OFS_SINK, 8'h01);
		aux(DPCD_POWER, 8'h02);
		chk("snoop_d3", {4'h0, lane_en}, 8'h00);
		rd(OFS_SINK, 8'h41);
		aux(DPCD_POWER, 8'h01);
		chk("snoop_wake", {4'h0, lane_en}, 8'h01);
		wr(OFS_SINK, 8'hff);
		rd(OFS_SINK, 8'h21);
		wr(OFS_SNOOP, 8'h01);
		wait_n(3);
		chk("snoop_off", {4'h0, lane_en}, 8'h0f);
		rd(OFS_SNOOP, 8'h01);
		wr(OFS_DP_EQ, 8'h0a);
		rd(OFS_DP_EQ, 8'h0a);
		chk("dp_eq_reg", {4'h0, dp_eq}, 8'h0a);
		rd(8'hff, 8'h00);
	endtask

	// ==========================================================
	// Clock, watchdog and main sequence
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Whole run needs roughly 2800 cycles
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		test_done();
	end
	initial begin
		{rst_b, lfps_up, lfps_dn, term, idle, ss, aux_v, reg_wr} = 8'h00;
		{strap, aux_a, aux_d, reg_a, reg_d} = '0;
		error_cnt = 0;
		n_tests = 0;
		do_reset(STRAP_PIN);
		t_default();
		t_configs();
		t_eq();
		t_usb();
		wait_n(2600);
		chk("pull_iso", {7'h0, iso}, 8'h01);
		t_snoop();
		test_done();
	end
endmodule // acmx_top_test
`default_nettype wire
